//--- verilog/wdrc_top.sv
/*
  wdrc_top: watchdog timer with keyed enable, reset-key register,
  reset cause flags and an event interrupt.
  Assumes ref_clk at 40 MHz; srcTick is a one-cycle pulse per period of
  the slow internal oscillator, synchronous to ref_clk; cpu strobes are
  one-cycle pulses from the core.
*/
// Decided for this implementation: the strobed register port and the placing of the registers.
// How it works
// - counter advances on slow oscillator ticks, timeout by power-of-two ratio
// - period select codes 0..7 give 2^8,10,12,14,15,16,17,18 periods
// - key 10101B disables watchdog, 01010B enables it
// - other key values reset device after delay, set watchdog-key flag
// - power-on loads enable key 01010B and period select 011
// - flag bit 0 set by key reset, cleared only by software zero or power-on reset
// - overflow in normal operation resets device, sets timeout flag
// - overflow in low power sets timeout, resets only PC and stack
// - count cleared by bad key, clear instruction or halt
// - reset key other than 55h or AAh resets device, sets its flag
// - reset key returns to 55h on all resets but low-power warm reset
// - power-on reset sets program counter to zero
// - power-on reset sets port data and direction registers to ones
// - flag bits 7..4 read zero; key flags power up cleared
// - halt sets power-down, clears timeout and watchdog count
// - power-down flag cleared by power-up or clear instruction
// - low-power overflow sets both timeout and power-down flags
`timescale 1ns/10ps
`default_nettype none
module wdrc_top
  import wdrc_pkg::*;
#(
  parameter int RESET_DELAY = DELAY_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // slow source tick
  input wire logic srcTick,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // cpu core
  input wire wdrc_cpu_t cpuIn,
  input wire logic lowSupplyEvent,
  // reset outputs
  output wdrc_rst_t rstOut,
  output logic [7:0] portPor,
  output logic timeoutFlag,
  output logic powerdownFlag,
  // interrupt
  output logic irq
);

  logic [4:0] enKey_ff;
  logic [2:0] psel_ff;
  logic [7:0] rkey_ff;
  logic [FLG_W-1:0] flags_ff;
  logic [IRQ_W-1:0] irqStat_ff;
  logic [IRQ_W-1:0] irqMask_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [DLY_W-1:0] dly_ff;
  logic to_ff;
  logic pdf_ff;
  logic devRst_ff;
  logic warm_ff;
  logic [7:0] rdata_ff;
  logic fromWdKey_ff;
  wdrc_state_t st_ff;

  logic wrCtrl;
  logic wrKey;
  logic wrFlags;
  logic wdEn;
  logic overflow;
  logic badWd;
  logic badRk;
  logic [CNT_W-1:0] limit;
  logic warmHit;
  logic hardHit;

  assign wrCtrl = regWr && (regAddr == REG_WDT_CTRL);
  assign wrKey = regWr && (regAddr == REG_RST_KEY);
  assign wrFlags = regWr && (regAddr == REG_RST_FLAGS);
  assign wdEn = (enKey_ff == KEY_ENABLE);
  assign badWd = !wdrc_key_ok(enKey_ff);
  assign badRk = !wdrc_rkey_ok(rkey_ff);
  assign limit = CNT_W'(1) << wdrc_exp(psel_ff);
  // at or past the limit, so a shorter period chosen mid-count cannot wrap
  assign overflow = wdEn && srcTick && (cnt_ff >= limit - CNT_W'(1));
  assign warmHit = overflow && cpuIn.lowPower;
  assign hardHit = overflow && !cpuIn.lowPower;

  // watchdog control register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enKey_ff <= KEY_POR;
      psel_ff <= PSEL_POR;
    end else if (devRst_ff) begin
      enKey_ff <= KEY_POR;
      psel_ff <= PSEL_POR;
    end else if (wrCtrl) begin
      enKey_ff <= regWdata[7:3];
      psel_ff <= regWdata[2:0];
    end
  end

  // reset key register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rkey_ff <= RKEY_POR;
    end else if (devRst_ff) begin
      rkey_ff <= RKEY_POR;
    end else if (wrKey) begin
      rkey_ff <= regWdata;
    end
  end

  // watchdog counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (devRst_ff || overflow) begin
      cnt_ff <= '0;
    end else if (cpuIn.clearInstr || cpuIn.haltInstr) begin
      cnt_ff <= '0;
    end else if (wrCtrl && !wdrc_key_ok(regWdata[7:3])) begin
      cnt_ff <= '0;
    end else if (wdEn && srcTick) begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  // key fault delay sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= WDRC_RUN;
      dly_ff <= '0;
      fromWdKey_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        WDRC_RUN: begin
          if (badWd || badRk) begin
            st_ff <= WDRC_KEYWAIT;
            dly_ff <= '0;
            fromWdKey_ff <= badWd;
          end
        end
        WDRC_KEYWAIT: begin
          if (srcTick) begin
            if (dly_ff == DLY_W'(RESET_DELAY - 1)) begin
              st_ff <= WDRC_RESET;
            end else begin
              dly_ff <= dly_ff + DLY_W'(1);
            end
          end
        end
        WDRC_RESET: begin
          st_ff <= WDRC_RUN;
        end
      endcase
    end
  end

  // device and warm reset pulses
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      devRst_ff <= 1'b0;
      warm_ff <= 1'b0;
    end else begin
      devRst_ff <= hardHit || (st_ff == WDRC_KEYWAIT && srcTick &&
        dly_ff == DLY_W'(RESET_DELAY - 1));
      warm_ff <= warmHit;
    end
  end

  // reset cause flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_ff <= '0;
    end else begin
      for (int i = 0; i < FLG_W; i++) begin
        if (wrFlags && !regWdata[i]) begin
          flags_ff[i] <= 1'b0;
        end
      end
      if (lowSupplyEvent) begin
        flags_ff[FLG_LOWSUP] <= 1'b1;
      end
      // sticky: a key reset only sets its own flag, never clears the other
      if (st_ff == WDRC_RESET && fromWdKey_ff) begin
        flags_ff[FLG_WDKEY] <= 1'b1;
      end
      if (st_ff == WDRC_RESET && !fromWdKey_ff) begin
        flags_ff[FLG_RKEY] <= 1'b1;
      end
    end
  end

  // timeout and power-down status
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
    end else if (overflow) begin
      to_ff <= 1'b1;
      if (cpuIn.lowPower) begin
        pdf_ff <= 1'b1;
      end
    end else if (cpuIn.haltInstr) begin
      pdf_ff <= 1'b1;
      to_ff <= 1'b0;
    end else if (cpuIn.clearInstr) begin
      pdf_ff <= 1'b0;
    end
  end

  // interrupt status and mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_ff <= '0;
      irqMask_ff <= '0;
    end else begin
      if (regWr && regAddr == REG_IRQ_MASK) begin
        irqMask_ff <= regWdata[IRQ_W-1:0];
      end
      for (int i = 0; i < IRQ_W; i++) begin
        if (regWr && regAddr == REG_IRQ_STAT && regWdata[i]) begin
          irqStat_ff[i] <= 1'b0;
        end
      end
      if (overflow) begin
        irqStat_ff[IRQ_TIMEOUT] <= 1'b1;
      end
      if (st_ff == WDRC_RUN && (badWd || badRk)) begin
        irqStat_ff[IRQ_KEYFAULT] <= 1'b1;
      end
    end
  end

  // read data, one cycle after strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        REG_WDT_CTRL: rdata_ff <= {enKey_ff, psel_ff};
        REG_RST_FLAGS: rdata_ff <= {4'h0, flags_ff};
        REG_RST_KEY: rdata_ff <= rkey_ff;
        REG_IRQ_STAT: rdata_ff <= {6'h00, irqStat_ff};
        REG_IRQ_MASK: rdata_ff <= {6'h00, irqMask_ff};
        REG_CPU_STAT: rdata_ff <= {6'h00, pdf_ff, to_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign regRdata = rdata_ff;
  assign irq = |(irqStat_ff & irqMask_ff);
  assign timeoutFlag = to_ff;
  assign powerdownFlag = pdf_ff;
  assign rstOut.deviceReset = devRst_ff;
  assign rstOut.warmReset = warm_ff;
  assign rstOut.pcClear = devRst_ff || warm_ff;
  assign portPor = PORT_POR;

endmodule
`default_nettype wire

//--- inc/wdrc_pkg.sv
/*
  wdrc_pkg: constants and types for the watchdog and reset-key control block.
  Assumes a single 40 MHz ref_clk domain; the slow watchdog source is an
  input tick synchronous to ref_clk.
*/
package wdrc_pkg;
  // register indices
  localparam logic [1:0] ADDR_WDT_CTRL = 2'h0;
  localparam logic [1:0] ADDR_RST_FLAGS = 2'h1;
  localparam logic [1:0] ADDR_RST_KEY = 2'h2;
  localparam logic [1:0] ADDR_IRQ_STAT = 2'h3;
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] REG_WDT_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_RST_FLAGS = 3'h1;
  localparam logic [ADDR_W-1:0] REG_RST_KEY = 3'h2;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 3'h3;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 3'h4;
  localparam logic [ADDR_W-1:0] REG_CPU_STAT = 3'h5;

  // watchdog control fields
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0A;
  localparam logic [4:0] KEY_POR = 5'h0A;
  localparam logic [2:0] PSEL_POR = 3'h3;
  localparam logic [7:0] WDT_CTRL_POR = 8'h53;

  // reset key register
  localparam logic [7:0] RKEY_A = 8'h55;
  localparam logic [7:0] RKEY_B = 8'hAA;
  localparam logic [7:0] RKEY_POR = 8'h55;

  // reset cause flag bit positions
  localparam int FLG_WDKEY = 0;
  localparam int FLG_SUPKEY = 1;
  localparam int FLG_LOWSUP = 2;
  localparam int FLG_RKEY = 3;
  localparam int FLG_W = 4;

  // interrupt status bit positions
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_KEYFAULT = 1;
  localparam int IRQ_W = 2;

  // counter: 19 bits of source periods, longest timeout 2^18
  localparam int CNT_W = 19;
  localparam int SRC_HZ = 32000;
  localparam int DELAY_DEF = 16;
  localparam int DLY_W = 16;

  // port reset value
  localparam logic [7:0] PORT_POR = 8'hFF;

  typedef enum logic [1:0] {
    WDRC_RUN,
    WDRC_KEYWAIT,
    WDRC_RESET
  } wdrc_state_t;

  typedef struct packed {
    logic clearInstr;
    logic haltInstr;
    logic lowPower;
  } wdrc_cpu_t;

  typedef struct packed {
    logic deviceReset;
    logic warmReset;
    logic pcClear;
  } wdrc_rst_t;

  // timeout length as exponent for a period select code
  function automatic logic [4:0] wdrc_exp(input logic [2:0] sel);
    unique case (sel)
      3'h0: wdrc_exp = 5'h08;
      3'h1: wdrc_exp = 5'h0A;
      3'h2: wdrc_exp = 5'h0C;
      3'h3: wdrc_exp = 5'h0E;
      3'h4: wdrc_exp = 5'h0F;
      3'h5: wdrc_exp = 5'h10;
      3'h6: wdrc_exp = 5'h11;
      3'h7: wdrc_exp = 5'h12;
    endcase
  endfunction

  function automatic logic wdrc_key_ok(input logic [4:0] k);
    wdrc_key_ok = (k == KEY_ENABLE) || (k == KEY_DISABLE);
  endfunction

  function automatic logic wdrc_rkey_ok(input logic [7:0] k);
    wdrc_rkey_ok = (k == RKEY_A) || (k == RKEY_B);
  endfunction
endpackage

//--- verification/wdrc_cpu_model.sv
/* wdrc_cpu_model: core side, slow tick and clear/halt strobes.
   assumes bench raises requests by nba after a clock edge */
`timescale 1ns/10ps
`default_nettype none
module wdrc_cpu_model
  import wdrc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bench requests
  input wire logic doClr,
  input wire logic doHalt,
  input wire logic sleep,
  // to block
  output wdrc_cpu_t cpuOut,
  output logic srcTick
);
  logic [1:0] divCnt_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) divCnt_ff <= 2'h0;
    else divCnt_ff <= divCnt_ff + 2'h1;
  end
  // slow source, one tick every 4 cycles
  assign srcTick = (divCnt_ff == 2'h3);
  assign cpuOut = '{doClr, doHalt, sleep};
endmodule
`default_nettype wire

//--- verification/wdrc_top_monitor.sv
/* wdrc_top_monitor: port assertions for wdrc_top.
   assumes bind to wdrc_top, small reset delay */
`timescale 1ns/10ps
`default_nettype none
module wdrc_top_monitor
  import wdrc_pkg::*;
#(
  parameter int RESET_DELAY = DELAY_DEF
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // core and outputs
  input wire wdrc_cpu_t cpuIn,
  input wire wdrc_rst_t rstOut,
  input wire logic [7:0] portPor,
  input wire logic timeoutFlag,
  input wire logic powerdownFlag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_bad_wkey;
    regWr && regAddr == REG_WDT_CTRL && regWdata[7:3] != 5'h0A &&
      regWdata[7:3] != 5'h15;
  endsequence
  sequence s_bad_rkey;
    regWr && regAddr == REG_RST_KEY && regWdata != 8'h55 &&
      regWdata != 8'hAA;
  endsequence
  sequence s_lp_flags;
    ##[0:1] (timeoutFlag && powerdownFlag);
  endsequence
  a_pulse_single: assert property (
    rstOut.deviceReset |=> !rstOut.deviceReset) else $error("long pulse");
  a_pc_follows: assert property (
    rstOut.deviceReset || rstOut.warmReset |-> rstOut.pcClear)
    else $error("pc clear missing");
  a_warm_flags: assert property (
    rstOut.warmReset |-> s_lp_flags) else $error("warm flags wrong");
  a_halt_pdf: assert property (
    cpuIn.haltInstr && !cpuIn.clearInstr |=> powerdownFlag)
    else $error("halt flag missing");
  a_clear_pdf: assert property (
    cpuIn.clearInstr && !cpuIn.haltInstr |=>
      !powerdownFlag || rstOut.warmReset) else $error("pdf not cleared");
  a_port_ones: assert property (
    portPor == 8'hFF) else $error("port value wrong");
  a_flag_upper: assert property (
    regRd && regAddr == REG_RST_FLAGS |=> regRdata[7:4] == 4'h0)
    else $error("flag upper bits set");
  a_wkey_reset: assert property (
    s_bad_wkey |-> ##[2:40] rstOut.deviceReset) else $error("no key reset");
  a_rkey_reset: assert property (
    s_bad_rkey |-> ##[2:40] rstOut.deviceReset) else $error("no rkey reset");
endmodule
bind wdrc_top wdrc_top_monitor #(.RESET_DELAY(RESET_DELAY)) u_wdrc_mon (
  .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuIn(cpuIn),
  .rstOut(rstOut), .portPor(portPor), .timeoutFlag(timeoutFlag),
  .powerdownFlag(powerdownFlag));
`default_nettype wire

//--- verification/wdrc_top_tb.sv
/* wdrc_top_tb: register level tests of the watchdog block.
   assumes cpu model as core and bound monitor */
`timescale 1ns/10ps
`default_nettype none
module wdrc_top_tb
  import wdrc_pkg::*;
;
  logic ref_clk, rst_n, regWr, regRd, doClr, doHalt, sleep, lowSup;
  logic srcTick, timeoutFlag, powerdownFlag, irq;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWdata, regRdata, portPor;
  wdrc_cpu_t cpuIn;
  wdrc_rst_t rstOut;
  int err_count = 0;
  int checks_done = 0;
  int n;
  wdrc_cpu_model u_wdrc_cpu_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .doClr(doClr), .doHalt(doHalt), .sleep(sleep), .cpuOut(cpuIn),
    .srcTick(srcTick));
  wdrc_top #(.RESET_DELAY(2)) u_wdrc_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .srcTick(srcTick), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuIn(cpuIn),
    .lowSupplyEvent(lowSup), .rstOut(rstOut), .portPor(portPor),
    .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic cpu(input logic c, input logic h);
    @(posedge ref_clk);
    doClr <= c;
    doHalt <= h;
    @(posedge ref_clk);
    doClr <= 1'b0;
    doHalt <= 1'b0;
  endtask
  // cycles until any reset pulse, bounded
  task automatic waitRst(input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (rstOut === 3'b000 && n < lim);
  endtask
  initial begin
    #500000;
    err_count++;
    conclude();
  end
  initial begin
    {regWr, regRd, doClr, doHalt, sleep, lowSup} = '0;
    regAddr = '0;
    regWdata = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(REG_WDT_CTRL, 8'h53);
    rd(REG_RST_FLAGS, 8'h00);
    rd(REG_RST_KEY, 8'h55);
    rd(3'h7, 8'h00);
    chk(portPor, 8'hFF);
    for (int p = 0; p < 2; p++) begin
      wr(REG_WDT_CTRL, {5'h0A, 3'(p)});
      cpu(1'b1, 1'b0);
      waitRst(9000);
      chk({5'h0, rstOut}, 8'h05);
      chk(8'(n > (4 << (8 + 2 * p)) - 9 && n < (4 << (8 + 2 * p)) + 9),
        8'h01);
      chk({7'h0, timeoutFlag}, 8'h01);
    end
    cpu(1'b0, 1'b1);
    #1 chk({6'h0, powerdownFlag, timeoutFlag}, 8'h02);
    rd(REG_CPU_STAT, 8'h02);
    cpu(1'b1, 1'b0);
    #1 chk({7'h0, powerdownFlag}, 8'h00);
    wr(REG_RST_KEY, 8'hAA);
    wr(REG_WDT_CTRL, 8'h50);
    sleep <= 1'b1;
    cpu(1'b0, 1'b1);
    waitRst(2000);
    chk({5'h0, rstOut}, 8'h03);
    chk({6'h0, timeoutFlag, powerdownFlag}, 8'h03);
    rd(REG_RST_KEY, 8'hAA);
    @(posedge ref_clk);
    sleep <= 1'b0;
    wr(REG_WDT_CTRL, 8'hA8);
    waitRst(1400);
    chk({5'h0, rstOut}, 8'h00);
    rd(REG_WDT_CTRL, 8'hA8);
    wr(REG_IRQ_STAT, 8'h03);
    wr(REG_IRQ_MASK, 8'h02);
    wr(REG_WDT_CTRL, 8'h00);
    waitRst(60);
    chk({5'h0, rstOut}, 8'h05);
    rd(REG_RST_FLAGS, 8'h01);
    rd(REG_WDT_CTRL, 8'h53);
    chk({7'h0, irq}, 8'h01);
    wr(REG_IRQ_MASK, 8'h00);
    #1 chk({7'h0, irq}, 8'h00);
    wr(REG_IRQ_MASK, 8'h02);
    wr(REG_IRQ_STAT, 8'h02);
    #1 chk({7'h0, irq}, 8'h00);
    wr(REG_RST_FLAGS, 8'hFF);
    rd(REG_RST_FLAGS, 8'h01);
    wr(REG_RST_FLAGS, 8'h00);
    rd(REG_RST_FLAGS, 8'h00);
    wr(REG_RST_KEY, 8'h00);
    waitRst(60);
    chk({5'h0, rstOut}, 8'h05);
    rd(REG_RST_FLAGS, 8'h08);
    rd(REG_RST_KEY, 8'h55);
    wr(REG_WDT_CTRL, 8'h00);
    waitRst(60);
    chk({5'h0, rstOut}, 8'h05);
    rd(REG_RST_FLAGS, 8'h09);
    @(posedge ref_clk);
    lowSup <= 1'b1;
    @(posedge ref_clk);
    lowSup <= 1'b0;
    rd(REG_RST_FLAGS, 8'h0D);
    conclude();
  end
endmodule
`default_nettype wire
